// [obcd_cfg.svh]
// option byte decoder constants: bit positions, encodings, reset values
// assumes nothing of its surroundings; included by the design package users
`ifndef OBCD_CFG_SVH
`define OBCD_CFG_SVH

// ----------------------------------------------------------------
// option byte 0
// ----------------------------------------------------------------
`define OBCD_OPT0_WLOCK_BIT   0
// ----------------------------------------------------------------
// option byte 1
// ----------------------------------------------------------------
`define OBCD_OPT1_IRQMAP_BIT  7
`define OBCD_OPT1_RSVD_BIT    6
`define OBCD_OPT1_CSRC_HI     5
`define OBCD_OPT1_CSRC_LO     4
`define OBCD_OPT1_BAND_HI     3
`define OBCD_OPT1_BAND_LO     1
`define OBCD_OPT1_DBL_BIT     0
// ----------------------------------------------------------------
// reset values (erased option bytes)
// ----------------------------------------------------------------
`define OBCD_OPT0_RESET       8'hff
`define OBCD_OPT1_RESET       8'hff
`define OBCD_OPT1_RSVD_DEF    1'b1

`endif

// [obcd_pkg.sv]
// option byte decoder types
// assumes obcd_cfg.svh is not needed here
package obcd_pkg;

  typedef enum logic [1:0] {
    OBCD_CSRC_RESONATOR,
    OBCD_CSRC_RESERVED,
    OBCD_CSRC_INTERNAL_RC,
    OBCD_CSRC_EXTERNAL
  } obcd_csrc_t;

  typedef enum logic [2:0] {
    OBCD_LOW_BAND,
    OBCD_MEDIUM_LOW_BAND,
    OBCD_MEDIUM_BAND,
    OBCD_HIGH_BAND,
    OBCD_VERY_LOW_BAND
  } obcd_band_t;

  typedef struct packed {
    logic       program_write_lock;
    logic       port_c_irq_map;
    obcd_csrc_t clock_source_select;
    obcd_band_t oscillator_band_select;
    logic       doubler_en;
    logic       config_illegal;
  } obcd_cfg_t;

endpackage : obcd_pkg

// [obcd_decoder.sv]
// option byte decoder: latches option bytes at reset, decodes clock, lock and irq map
// assumes option bytes are stable from nonvolatile storage on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "obcd_cfg.svh"

module obcd_decoder (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // option bytes from storage
  input  wire logic [7:0]        opt_byte0,
  input  wire logic [7:0]        opt_byte1,
  // program memory write requests
  input  wire logic              pgm_erase_req,
  input  wire logic              pgm_write_req,
  output logic                   pgm_erase_grant,
  output logic                   pgm_write_grant,
  // external interrupt pins
  input  wire logic [7:0]        port_a_pins,
  input  wire logic [7:0]        port_b_pins,
  input  wire logic [5:0]        port_c_pins,
  output logic [13:0]            ext_irq_line_zero,
  output logic [13:0]            ext_irq_line_one,
  // decoded settings
  output obcd_pkg::obcd_cfg_t    cfg,
  output logic                   doubler_bypass
);

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  logic [7:0] opt0_q;
  logic [7:0] opt1_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      opt0_q <= opt_byte0;
      opt1_q <= opt_byte1;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic obcd_pkg::obcd_band_t band_dec(input logic [2:0] f);
    if (f[2]) begin
      band_dec = obcd_pkg::OBCD_VERY_LOW_BAND;
    end else begin
      case (f[1:0])
        2'h0:    band_dec = obcd_pkg::OBCD_LOW_BAND;
        2'h1:    band_dec = obcd_pkg::OBCD_MEDIUM_LOW_BAND;
        2'h2:    band_dec = obcd_pkg::OBCD_MEDIUM_BAND;
        default: band_dec = obcd_pkg::OBCD_HIGH_BAND;
      endcase
    end
  endfunction : band_dec

  wire        lock_w   = opt0_q[`OBCD_OPT0_WLOCK_BIT];
  wire        map_w    = opt1_q[`OBCD_OPT1_IRQMAP_BIT];
  wire [1:0]  csrc_w   = opt1_q[`OBCD_OPT1_CSRC_HI:`OBCD_OPT1_CSRC_LO];
  wire [2:0]  bandf_w  = opt1_q[`OBCD_OPT1_BAND_HI:`OBCD_OPT1_BAND_LO];
  wire        dbl_en_w = ~opt1_q[`OBCD_OPT1_DBL_BIT];
  wire        rsvd_bad = opt1_q[`OBCD_OPT1_RSVD_BIT] != `OBCD_OPT1_RSVD_DEF;
  wire        dbl_bad  = dbl_en_w &&
                         ((csrc_w == 2'h2) ||
                          (band_dec(bandf_w) != obcd_pkg::OBCD_MEDIUM_LOW_BAND));

  assign cfg.program_write_lock     = lock_w;
  assign cfg.port_c_irq_map         = map_w;
  assign cfg.clock_source_select    = obcd_pkg::obcd_csrc_t'(csrc_w);
  assign cfg.oscillator_band_select = band_dec(bandf_w);
  assign cfg.doubler_en             = dbl_en_w;
  assign cfg.config_illegal         = dbl_bad | rsvd_bad;
  assign doubler_bypass             = ~dbl_en_w;

  // ----------------------------------------------------------------
  // write lock
  // ----------------------------------------------------------------
  assign pgm_erase_grant = pgm_erase_req & ~lock_w & ~srst;
  assign pgm_write_grant = pgm_write_req & ~lock_w & ~srst;

  // ----------------------------------------------------------------
  // interrupt mapping
  // ----------------------------------------------------------------
  assign ext_irq_line_zero = map_w ? {6'h00, port_a_pins} : {port_c_pins, port_a_pins};
  assign ext_irq_line_one  = map_w ? {port_c_pins, port_b_pins} : {6'h00, port_b_pins};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_lock_refuses: assert property (@(posedge clk) disable iff (srst)
    lock_w |-> !pgm_erase_grant && !pgm_write_grant)
    else $error("grant while locked");
  chk_irq_map_c: assert property (@(posedge clk) disable iff (srst)
    map_w |-> ext_irq_line_one[13:8] == port_c_pins && ext_irq_line_zero[13:8] == 6'h00)
    else $error("port c map wrong");
  chk_csrc_dec: assert property (@(posedge clk) disable iff (srst)
    opt1_q[5:4] == 2'h0 |-> cfg.clock_source_select == obcd_pkg::OBCD_CSRC_RESONATOR)
    else $error("clock source decode wrong");
  chk_band_vlow: assert property (@(posedge clk) disable iff (srst)
    opt1_q[3] |-> cfg.oscillator_band_select == obcd_pkg::OBCD_VERY_LOW_BAND)
    else $error("band decode wrong");
  chk_doubler_bit: assert property (@(posedge clk) disable iff (srst)
    doubler_bypass == opt1_q[0] && cfg.doubler_en != doubler_bypass)
    else $error("doubler decode wrong");
  chk_doubler_rc: assert property (@(posedge clk) disable iff (srst)
    (dbl_en_w && csrc_w == 2'h2) |-> cfg.config_illegal)
    else $error("doubler with rc not flagged");
  chk_doubler_band: assert property (@(posedge clk) disable iff (srst)
    (dbl_en_w && bandf_w != 3'h1) |-> cfg.config_illegal)
    else $error("doubler band not flagged");
  chk_held_const: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> $stable(opt0_q) && $stable(opt1_q))
    else $error("options changed after reset");

  // ----------------------------------------------------------------
  // capture at reset release
  // ----------------------------------------------------------------
  sequence seq_rst_release;
    srst ##1 !srst;
  endsequence : seq_rst_release

  chk_capture_last: assert property (@(posedge clk)
    seq_rst_release |-> opt0_q == $past(opt_byte0) && opt1_q == $past(opt_byte1))
    else $error("capture not taken at last reset edge");

  // ----------------------------------------------------------------
  // write lock checks
  // ----------------------------------------------------------------
  chk_grant_open: assert property (@(posedge clk) disable iff (srst)
    !lock_w |-> pgm_erase_grant == pgm_erase_req && pgm_write_grant == pgm_write_req)
    else $error("request refused while unlocked");

  chk_grant_reset: assert property (@(posedge clk)
    srst |-> !pgm_erase_grant && !pgm_write_grant)
    else $error("grant during reset");

  chk_lock_field: assert property (@(posedge clk) disable iff (srst)
    cfg.program_write_lock == opt0_q[0])
    else $error("lock field wrong");

  // ----------------------------------------------------------------
  // interrupt map checks
  // ----------------------------------------------------------------
  chk_irq_map_zero: assert property (@(posedge clk) disable iff (srst)
    !map_w |-> ext_irq_line_zero[13:8] == port_c_pins && ext_irq_line_one[13:8] == 6'h00)
    else $error("port c map zero wrong");

  chk_irq_low_bits: assert property (@(posedge clk) disable iff (srst)
    ext_irq_line_zero[7:0] == port_a_pins && ext_irq_line_one[7:0] == port_b_pins)
    else $error("port a or b map wrong");

  chk_map_field: assert property (@(posedge clk) disable iff (srst)
    cfg.port_c_irq_map == opt1_q[7])
    else $error("map field wrong");

  // ----------------------------------------------------------------
  // clock source checks
  // ----------------------------------------------------------------
  chk_csrc_rsvd: assert property (@(posedge clk) disable iff (srst)
    opt1_q[5:4] == 2'h1 |-> cfg.clock_source_select == obcd_pkg::OBCD_CSRC_RESERVED)
    else $error("reserved source decode wrong");

  chk_csrc_rc: assert property (@(posedge clk) disable iff (srst)
    opt1_q[5:4] == 2'h2 |-> cfg.clock_source_select == obcd_pkg::OBCD_CSRC_INTERNAL_RC)
    else $error("rc source decode wrong");

  chk_csrc_ext: assert property (@(posedge clk) disable iff (srst)
    opt1_q[5:4] == 2'h3 |-> cfg.clock_source_select == obcd_pkg::OBCD_CSRC_EXTERNAL)
    else $error("external source decode wrong");

  // ----------------------------------------------------------------
  // band checks
  // ----------------------------------------------------------------
  chk_band_low: assert property (@(posedge clk) disable iff (srst)
    opt1_q[3:1] == 3'h0 |-> cfg.oscillator_band_select == obcd_pkg::OBCD_LOW_BAND)
    else $error("low band decode wrong");

  chk_band_mlow: assert property (@(posedge clk) disable iff (srst)
    opt1_q[3:1] == 3'h1 |-> cfg.oscillator_band_select == obcd_pkg::OBCD_MEDIUM_LOW_BAND)
    else $error("medium low band decode wrong");

  chk_band_med: assert property (@(posedge clk) disable iff (srst)
    opt1_q[3:1] == 3'h2 |-> cfg.oscillator_band_select == obcd_pkg::OBCD_MEDIUM_BAND)
    else $error("medium band decode wrong");

  chk_band_high: assert property (@(posedge clk) disable iff (srst)
    opt1_q[3:1] == 3'h3 |-> cfg.oscillator_band_select == obcd_pkg::OBCD_HIGH_BAND)
    else $error("high band decode wrong");

  // ----------------------------------------------------------------
  // doubler and reserved bit checks
  // ----------------------------------------------------------------
  chk_doubler_on: assert property (@(posedge clk) disable iff (srst)
    !opt1_q[0] |-> cfg.doubler_en && !doubler_bypass)
    else $error("doubler not enabled");

  chk_doubler_legal: assert property (@(posedge clk) disable iff (srst)
    (!opt1_q[0] && opt1_q[5:4] != 2'h2 && opt1_q[3:1] == 3'h1 && opt1_q[6]) |-> !cfg.config_illegal)
    else $error("legal doubler setup flagged");

  chk_rsvd_flag: assert property (@(posedge clk) disable iff (srst)
    !opt1_q[6] |-> cfg.config_illegal)
    else $error("reserved bit change not flagged");

  chk_bypass_legal: assert property (@(posedge clk) disable iff (srst)
    (opt1_q[0] && opt1_q[6]) |-> !cfg.config_illegal)
    else $error("bypassed doubler flagged");

endmodule : obcd_decoder
`default_nettype wire

// [tb.sv]
// testbench for the option byte decoder: random option bytes, pins and requests
// assumes obcd_pkg and obcd_decoder are compiled before it
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic                clk = 1'b0;
  logic                srst = 1'b1;
  logic [7:0]          ob0 = 8'hff, ob1 = 8'hff, c0 = 8'hff, c1 = 8'hff, pa = 8'h00, pb = 8'h00;
  logic [5:0]          pc = 6'h00;
  logic                er = 1'b0, wr = 1'b0, er_g, wr_g, byp;
  logic [13:0]         irq0, irq1;
  obcd_pkg::obcd_cfg_t cfg;
  integer              seed, error_cnt = 0, tests_run = 0, i;
  logic [7:0]          corner [4] = '{8'h42, 8'h62, 8'h44, 8'hff};
  always #25 clk = ~clk;
  obcd_decoder uut (.clk(clk), .srst(srst), .opt_byte0(ob0), .opt_byte1(ob1),
    .pgm_erase_req(er), .pgm_write_req(wr), .pgm_erase_grant(er_g), .pgm_write_grant(wr_g),
    .port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc), .ext_irq_line_zero(irq0),
    .ext_irq_line_one(irq1), .cfg(cfg), .doubler_bypass(byp));
  // ----------------------------------------------------------------
  // expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [8:0] exp_cfg(input logic [7:0] b0, input logic [7:0] b1);
    logic [2:0] band;
    logic       ill;
    band = b1[3] ? 3'h4 : b1[3:1];
    ill  = (~b1[0] & ((b1[5:4] == 2'h2) | (b1[3:1] != 3'h1))) | ~b1[6];
    return {b0[0], b1[7], b1[5:4], band, ~b1[0], ill};
  endfunction : exp_cfg
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic drive_rand();
    logic [31:0] r;
    r = $random(seed);
    {pa, pb, pc, er, wr} = r[23:0];
  endtask : drive_rand
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    seed = 32'h692a600f;
    repeat (4) @(posedge clk);
    #5;
    for (i = 0; i < 200; i++) begin
      srst = 1'b1;
      c0 = $random(seed);
      c1 = (i < 4) ? corner[i] : ($random(seed) | 8'h40);
      ob0 = c0;
      ob1 = c1;
      drive_rand();
      #1 chk(er_g, 1'b0);
      chk(wr_g, 1'b0);
      @(posedge clk);
      #5;
      srst = 1'b0;
      repeat (2) begin
        ob0 = $random(seed);
        ob1 = $random(seed);
        drive_rand();
        #1 chk(cfg, exp_cfg(c0, c1));
        chk(byp, c1[0]);
        chk({er_g, wr_g}, {er, wr} & {2{~c0[0]}});
        chk(irq0, c1[7] ? {6'h00, pa} : {pc, pa});
        chk(irq1, c1[7] ? {pc, pb} : {6'h00, pb});
        @(posedge clk);
        #5;
      end
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
